// >>> pkg/afs_pkg.sv
// Purpose: Shared constants and carriers for the audio frame/slot sequencer
// Assumes: 32-bit Avalon-MM register window, byte addresses
// Notes:   Offsets, field positions and carriers; rules follow
// Function
// RL1: Shared clocking: receiver uses transmit clock, sync
// RL2: Software matches frame bit totals when shared
// RL3: Software matches mode, sync source, width when shared
// RL4: Shared clocking ignores receive bit clock control
// RL5: Independent clocking: separate clocks, syncs, events
// RL6: Burst: one slot per sync edge
// RL7: Burst sync-to-data delay of 0, 1, 2
// RL8: Burst sync pulse is one bit wide; code makes it a slot wide when the sync width bit is set
// RL9: Internal transmit burst sync waits for data
// RL10: Internal receive burst sync waits for read
// RL11: Software enables slot 0 only in burst
// RL12: Software sets 2 to 32 TDM slots
// RL13: Sequencers count slots from sync, check mask
// RL14: Inactive slot: no buffer update, no event
// RL15: Inactive slot drive: hi-z, low or high
// RL16: Transmit event for slot N in N-1
// RL17: Copy in slot N raises event for N+1
// RL18: Skipped slots: event in first bit of M-1
// RL19: Receive event only after data stored
// RL20: Receiver supports 384-slot block mode
// RL21: Software enables all receive slots in 384 mode
// RL22: Receive sync driven by start-of-block signal
package afs_pkg;
  // Register byte offsets
  localparam logic [7:0] AFS_OFS_CTRL   = 8'h00;
  localparam logic [7:0] AFS_OFS_TXFMT  = 8'h04;
  localparam logic [7:0] AFS_OFS_RXFMT  = 8'h08;
  localparam logic [7:0] AFS_OFS_TXMASK = 8'h0C;
  localparam logic [7:0] AFS_OFS_RXMASK = 8'h10;
  localparam logic [7:0] AFS_OFS_TXDATA = 8'h14;
  localparam logic [7:0] AFS_OFS_RXDATA = 8'h18;
  localparam logic [7:0] AFS_OFS_STAT   = 8'h1C;
  localparam logic [7:0] AFS_OFS_RXBC   = 8'h20;
  // Control field positions
  localparam int AFS_C_INDEP = 0;  // independent_clocking_select
  localparam int AFS_C_TXSRC = 1;  // tx_sync_source, 1 = internal
  localparam int AFS_C_RXSRC = 2;  // rx_sync_source, 1 = internal
  localparam int AFS_C_TXWID = 3;  // tx_sync_width, 0 = one bit
  localparam int AFS_C_RXWID = 4;  // rx_sync_width, 0 = one bit
  localparam int AFS_C_TXDLY = 5;  // Two-bit transmit data delay
  localparam int AFS_C_RXDLY = 7;  // Two-bit receive data delay
  localparam int AFS_C_DRV   = 9;  // Two-bit inactive_slot_drive
  localparam int AFS_C_TXEN  = 11; // Transmit sequencer run
  localparam int AFS_C_RXEN  = 12; // Receive sequencer run
  // Format and status field positions
  localparam int AFS_F_CNT    = 0;  // Nine-bit slot count
  localparam int AFS_F_SZ     = 16; // Five-bit slot size minus one
  localparam int AFS_S_TXSLOT = 4;
  localparam int AFS_S_RXSLOT = 16;
  // Reset values
  localparam logic [31:0] AFS_RST_CTRL = 32'h0000_0000;
  localparam logic [31:0] AFS_RST_FMT  = 32'h0000_0000;
  localparam logic [31:0] AFS_RST_MASK = 32'h0000_0000;
  // Slot count codes and inactive drive codes
  localparam logic [8:0] AFS_BURST     = 9'h000;
  localparam logic [8:0] AFS_DIR_SLOTS = 9'h180;
  localparam logic [1:0] AFS_DRV_HIZ   = 2'h0;
  localparam logic [1:0] AFS_DRV_LOW   = 2'h1;
  localparam logic [1:0] AFS_DRV_HIGH  = 2'h2;
  // One direction's sequencer
  typedef struct packed {
    logic        in_frame; // Slots being shifted
    logic [1:0]  dly;      // Remaining sync-to-data delay
    logic [4:0]  bitc;     // Bit within slot
    logic [8:0]  slot;     // Slot within frame
    logic [31:0] shift;    // serializer_shift_register
    logic [31:0] data;     // serializer_buffer
    logic        full;     // Buffer holds unserviced word
    logic        fs_gen;   // Internally made frame sync
    logic [4:0]  fs_cnt;   // Extra bit clocks of sync
    logic        fs_prev;  // Sync level at last bit event
  } afs_seq_t;
  // Whole block state
  typedef struct packed {
    logic [31:0] ctrl, txfmt, rxfmt, txmask, rxmask;
    logic        rxbc;     // rx_bit_clock_control: sample on fall
    logic [2:0]  tck, rck; // Bit clock synchronisers plus edge tap
    logic [1:0]  tfs, rfs, rdat;
    afs_seq_t    tx, rx;
    logic        tx_pin, tx_oe_n, tfs_oe_n, rfs_oe_n;
    logic        wreq, tx_dma, rx_dma;
    logic [31:0] rdata;
  } afs_state_t;
endpackage : afs_pkg

// >>> hw/afs_seq_top.sv
// Purpose: Frame and slot sequencing for one transmit and one receive serializer
// Assumes: Bit clocks far slower than clk_sys_i; rising-edge frame syncs
// Notes:   Transmit shifts on bit clock fall, receive samples on rise, or on fall when independent with rxbc set
`timescale 1ns/1ps
module afs_seq_top (
  // System
  input  wire logic        clk_sys_i,
  input  wire logic        rst_i,
  // Avalon-MM slave
  input  wire logic [7:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  input  wire logic [3:0]  avs_byteenable_i,
  output logic      [31:0] avs_readdata_o,
  output logic             avs_waitrequest_o,
  // Bit clocks
  input  wire logic        tx_bit_clock_pin_i,
  input  wire logic        rx_bit_clock_pin_i,
  // Frame syncs
  input  wire logic        tx_frame_sync_pin_i,
  output logic             tx_frame_sync_pin_o,
  output logic             tx_frame_sync_pin_oe_n_o,
  input  wire logic        rx_frame_sync_pin_i,
  output logic             rx_frame_sync_pin_o,
  output logic             rx_frame_sync_pin_oe_n_o,
  // Serial data
  output logic             serial_data_pin0_o,
  output logic             serial_data_pin0_oe_n_o,
  input  wire logic        serial_data_pin1_i,
  // DMA requests
  output logic             tx_dma_request_o,
  output logic             rx_dma_request_o
);
  afs_pkg::afs_state_t s_reg, s_next; // All state

  // Slot enable, with 384-slot mode forcing every slot on
  function automatic logic slot_on(input logic [31:0] m, input logic [8:0] c,
                                   input logic [8:0] sl);
    return (c == afs_pkg::AFS_DIR_SLOTS) | m[sl[4:0]];
  endfunction : slot_on

  // Following slot, wrapping at frame end
  function automatic logic [8:0] nxt(input logic [8:0] sl, input logic [8:0] last);
    return (sl == last) ? afs_pkg::AFS_BURST : 9'(sl + 9'h001);
  endfunction : nxt

  // Decoded controls
  logic       indep, tx_en, rx_en, txsrc, rxsrc;
  logic [1:0] tdly, rdly, drv;
  logic [8:0] tx_cnt, rx_cnt, tx_last, rx_last;
  logic [4:0] tx_sz, rx_sz;
  assign indep   = s_reg.ctrl[afs_pkg::AFS_C_INDEP];
  assign tx_en   = s_reg.ctrl[afs_pkg::AFS_C_TXEN];
  assign rx_en   = s_reg.ctrl[afs_pkg::AFS_C_RXEN];
  assign txsrc   = s_reg.ctrl[afs_pkg::AFS_C_TXSRC];
  assign rxsrc   = s_reg.ctrl[afs_pkg::AFS_C_RXSRC];
  assign tdly    = s_reg.ctrl[afs_pkg::AFS_C_TXDLY +: 2];
  assign rdly    = s_reg.ctrl[afs_pkg::AFS_C_RXDLY +: 2];
  assign drv     = s_reg.ctrl[afs_pkg::AFS_C_DRV +: 2];
  assign tx_cnt  = s_reg.txfmt[afs_pkg::AFS_F_CNT +: 9];
  assign rx_cnt  = s_reg.rxfmt[afs_pkg::AFS_F_CNT +: 9];
  assign tx_sz   = s_reg.txfmt[afs_pkg::AFS_F_SZ +: 5];
  assign rx_sz   = s_reg.rxfmt[afs_pkg::AFS_F_SZ +: 5];
  assign tx_last = (tx_cnt == afs_pkg::AFS_BURST) ? tx_cnt : 9'(tx_cnt - 9'h001);
  assign rx_last = (rx_cnt == afs_pkg::AFS_BURST) ? rx_cnt : 9'(rx_cnt - 9'h001);

  // Bit clock edges from the second synchroniser stage only
  logic tck_rise, tck_fall, rck_rise, rck_fall, tx_ev, rx_ev;
  assign tck_rise = s_reg.tck[1] & ~s_reg.tck[2];
  assign tck_fall = ~s_reg.tck[1] & s_reg.tck[2];
  assign rck_rise = s_reg.rck[1] & ~s_reg.rck[2];
  assign rck_fall = ~s_reg.rck[1] & s_reg.rck[2];
  assign tx_ev    = tx_en & tck_fall;
  // Shared mode takes transmit clock; receive control only counts when independent
  assign rx_ev    = rx_en & (indep ? (s_reg.rxbc ? rck_fall : rck_rise) : tck_rise); // RL1 RL4 RL5

  // Frame sync sources and active edges
  logic tx_fs, rx_fs, tx_edge, rx_edge;
  assign tx_fs   = txsrc ? s_reg.tx.fs_gen : s_reg.tfs[1];
  assign rx_fs   = indep ? (rxsrc ? s_reg.rx.fs_gen : s_reg.rfs[1]) : tx_fs; // RL1 RL5
  assign tx_edge = tx_fs & ~s_reg.tx.fs_prev;
  assign rx_edge = rx_fs & ~s_reg.rx.fs_prev;

  // Per-event slot position; an edge restarts at slot 0 bit 0
  logic [1:0] tx_d0, rx_d0;
  logic [4:0] tx_bit, rx_bit;
  logic [8:0] tx_sl, rx_sl;
  logic       tx_go, rx_go, tx_act, rx_act, tx_nxt, tx_first, tx_req_c, tx_copy;
  logic       rx_store;
  assign tx_d0    = tx_edge ? tdly : s_reg.tx.dly;
  assign rx_d0    = rx_edge ? rdly : s_reg.rx.dly;
  // Clocks outside a frame shift nothing
  assign tx_go    = tx_ev & (tx_edge | s_reg.tx.in_frame) & (tx_d0 == 2'h0); // RL6 RL7
  assign rx_go    = rx_ev & (rx_edge | s_reg.rx.in_frame) & (rx_d0 == 2'h0); // RL6 RL7
  assign tx_bit   = tx_edge ? 5'h00 : s_reg.tx.bitc;
  assign rx_bit   = rx_edge ? 5'h00 : s_reg.rx.bitc;
  assign tx_sl    = tx_edge ? afs_pkg::AFS_BURST : s_reg.tx.slot;
  assign rx_sl    = rx_edge ? afs_pkg::AFS_BURST : s_reg.rx.slot;
  assign tx_act   = slot_on(s_reg.txmask, tx_cnt, tx_sl); // RL13
  assign rx_act   = slot_on(s_reg.rxmask, rx_cnt, rx_sl); // RL13 RL20
  assign tx_nxt   = slot_on(s_reg.txmask, tx_cnt, nxt(tx_sl, tx_last));
  assign tx_first = tx_go & (tx_bit == 5'h00);
  // Event for next active slot in first bit of the slot before it
  assign tx_req_c = tx_first & tx_nxt; // RL16 RL17 RL18
  assign tx_copy  = tx_first & tx_act; // RL14
  assign rx_store = rx_go & (rx_bit == rx_sz) & rx_act; // RL14 RL19

  // Bus handshake: request seen, answered with waitrequest low next cycle
  logic req, acc, tx_wr;
  logic [31:0] bmask;
  assign req   = avs_read_i | avs_write_i;
  assign acc   = req & ~s_reg.wreq;
  assign tx_wr = acc & avs_write_i & (avs_address_i == afs_pkg::AFS_OFS_TXDATA);
  assign bmask = {{8{avs_byteenable_i[3]}}, {8{avs_byteenable_i[2]}},
                  {8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};

  // Next state
  always_comb begin
    logic [31:0] rd;
    logic [31:0] sh;
    rd = '0;
    sh = '0;
    s_next = s_reg;
    // Synchronisers
    s_next.tck  = {s_reg.tck[1:0], tx_bit_clock_pin_i};
    s_next.rck  = {s_reg.rck[1:0], rx_bit_clock_pin_i};
    s_next.tfs  = {s_reg.tfs[0], tx_frame_sync_pin_i};
    s_next.rfs  = {s_reg.rfs[0], rx_frame_sync_pin_i};
    s_next.rdat = {s_reg.rdat[0], serial_data_pin1_i};
    s_next.tx_dma = 1'b0;
    s_next.rx_dma = 1'b0;
    s_next.tfs_oe_n = ~txsrc;
    s_next.rfs_oe_n = ~(rxsrc & indep);
    // Read mux
    unique case (avs_address_i)
      afs_pkg::AFS_OFS_CTRL:   rd = s_reg.ctrl;
      afs_pkg::AFS_OFS_TXFMT:  rd = s_reg.txfmt;
      afs_pkg::AFS_OFS_RXFMT:  rd = s_reg.rxfmt;
      afs_pkg::AFS_OFS_TXMASK: rd = s_reg.txmask;
      afs_pkg::AFS_OFS_RXMASK: rd = s_reg.rxmask;
      afs_pkg::AFS_OFS_TXDATA: rd = s_reg.tx.data;
      afs_pkg::AFS_OFS_RXDATA: rd = s_reg.rx.data;
      afs_pkg::AFS_OFS_RXBC:   rd[0] = s_reg.rxbc;
      afs_pkg::AFS_OFS_STAT: begin
        rd[3:0] = {s_reg.rx.in_frame, s_reg.tx.in_frame, s_reg.rx.full, s_reg.tx.full};
        rd[afs_pkg::AFS_S_TXSLOT +: 9] = s_reg.tx.slot;
        rd[afs_pkg::AFS_S_RXSLOT +: 9] = s_reg.rx.slot;
      end
      default: rd = '0; // Unmapped reads as zero
    endcase
    // Bus phases
    s_next.wreq = 1'b1;
    if (req && s_reg.wreq) begin
      s_next.wreq  = 1'b0;
      s_next.rdata = rd;
    end else if (acc && avs_write_i) begin
      unique case (avs_address_i)
        afs_pkg::AFS_OFS_CTRL:   s_next.ctrl = (s_reg.ctrl & ~bmask) | (avs_writedata_i & bmask);
        afs_pkg::AFS_OFS_TXFMT:  s_next.txfmt = (s_reg.txfmt & ~bmask) | (avs_writedata_i & bmask);
        afs_pkg::AFS_OFS_RXFMT:  s_next.rxfmt = (s_reg.rxfmt & ~bmask) | (avs_writedata_i & bmask);
        afs_pkg::AFS_OFS_TXMASK: s_next.txmask = (s_reg.txmask & ~bmask) | (avs_writedata_i & bmask);
        afs_pkg::AFS_OFS_RXMASK: s_next.rxmask = (s_reg.rxmask & ~bmask) | (avs_writedata_i & bmask);
        afs_pkg::AFS_OFS_RXBC:   if (avs_byteenable_i[0]) s_next.rxbc = avs_writedata_i[0];
        default: ; // Transmit data written below; read-only or unmapped: ignored
      endcase
    end else if (acc && avs_address_i == afs_pkg::AFS_OFS_RXDATA) begin
      s_next.rx.full = 1'b0; // Read services buffer; a store below wins
    end

    // Transmit sequencer
    if (!tx_en) begin
      s_next.tx.in_frame = 1'b0;
      s_next.tx.fs_gen   = 1'b0;
      s_next.tx_oe_n     = 1'b1;
    end else if (tx_ev) begin
      s_next.tx.fs_prev = tx_fs;
      if (s_reg.tx.fs_gen) begin
        if (s_reg.tx.fs_cnt == 5'h00) s_next.tx.fs_gen = 1'b0; // RL8
        else s_next.tx.fs_cnt = 5'(s_reg.tx.fs_cnt - 5'h01);
      end else if (txsrc && !s_reg.tx.in_frame &&
                   (tx_cnt != afs_pkg::AFS_BURST || s_reg.tx.full)) begin
        s_next.tx.fs_gen = 1'b1; // RL9
        s_next.tx.fs_cnt = s_reg.ctrl[afs_pkg::AFS_C_TXWID] ? tx_sz : 5'h00; // RL8
      end
      if (tx_edge) s_next.tx.in_frame = 1'b1;
      if ((tx_edge || s_reg.tx.in_frame) && tx_d0 != 2'h0) s_next.tx.dly = 2'(tx_d0 - 2'h1); // RL7
      else s_next.tx.dly = 2'h0;
      if (tx_go) begin
        sh = tx_copy ? s_reg.tx.data : s_reg.tx.shift;
        if (tx_copy) s_next.tx.full = 1'b0;
        if (tx_act) begin
          s_next.tx_pin  = sh[tx_sz];
          s_next.tx_oe_n = 1'b0;
        end else begin
          // Inactive slot pin state
          unique case (drv)
            afs_pkg::AFS_DRV_LOW:  {s_next.tx_pin, s_next.tx_oe_n} = 2'b00; // RL15
            afs_pkg::AFS_DRV_HIGH: {s_next.tx_pin, s_next.tx_oe_n} = 2'b10; // RL15
            default:               {s_next.tx_pin, s_next.tx_oe_n} = 2'b01; // RL15
          endcase
        end
        s_next.tx.shift = sh << 1;
        s_next.tx_dma   = tx_req_c; // RL16 RL17 RL18
        s_next.tx.slot  = tx_sl;
        s_next.tx.bitc  = 5'(tx_bit + 5'h01);
        if (tx_bit == tx_sz) begin
          s_next.tx.bitc = 5'h00;
          if (tx_sl == tx_last) s_next.tx.in_frame = 1'b0; // RL6 RL13
          else s_next.tx.slot = nxt(tx_sl, tx_last); // RL13
        end
      end else if (!s_reg.tx.in_frame && !tx_edge) begin
        s_next.tx_oe_n = 1'b1; // Released between frames
      end
    end
    // Software write sets the buffer; beats a same-cycle copy
    if (tx_wr) begin
      s_next.tx.data = (s_reg.tx.data & ~bmask) | (avs_writedata_i & bmask);
      s_next.tx.full = 1'b1;
    end

    // Receive sequencer
    if (!rx_en) begin
      s_next.rx.in_frame = 1'b0;
      s_next.rx.fs_gen   = 1'b0;
    end else if (rx_ev) begin
      s_next.rx.fs_prev = rx_fs;
      if (s_reg.rx.fs_gen) begin
        if (s_reg.rx.fs_cnt == 5'h00) s_next.rx.fs_gen = 1'b0; // RL8
        else s_next.rx.fs_cnt = 5'(s_reg.rx.fs_cnt - 5'h01);
      end else if (indep && rxsrc && !s_reg.rx.in_frame &&
                   (rx_cnt != afs_pkg::AFS_BURST || !s_reg.rx.full)) begin
        s_next.rx.fs_gen = 1'b1; // RL10
        s_next.rx.fs_cnt = s_reg.ctrl[afs_pkg::AFS_C_RXWID] ? rx_sz : 5'h00; // RL8
      end
      if (rx_edge) s_next.rx.in_frame = 1'b1;
      if ((rx_edge || s_reg.rx.in_frame) && rx_d0 != 2'h0) s_next.rx.dly = 2'(rx_d0 - 2'h1); // RL7
      else s_next.rx.dly = 2'h0;
      if (rx_go) begin
        sh = {s_reg.rx.shift[30:0], s_reg.rdat[1]};
        s_next.rx.shift = sh;
        if (rx_store) begin
          s_next.rx.data = sh & ~(32'hFFFF_FFFE << rx_sz); // RL19
          s_next.rx.full = 1'b1;
          s_next.rx_dma  = 1'b1; // RL19
        end
        s_next.rx.slot = rx_sl;
        s_next.rx.bitc = 5'(rx_bit + 5'h01);
        if (rx_bit == rx_sz) begin
          s_next.rx.bitc = 5'h00;
          if (rx_sl == rx_last) s_next.rx.in_frame = 1'b0; // RL6 RL13 RL20
          else s_next.rx.slot = nxt(rx_sl, rx_last); // RL13 RL20
        end
      end
    end
  end

  // State register; idle, pins released, bus busy during reset
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      s_reg          <= '0;
      s_reg.ctrl     <= afs_pkg::AFS_RST_CTRL;
      s_reg.txfmt    <= afs_pkg::AFS_RST_FMT;
      s_reg.rxfmt    <= afs_pkg::AFS_RST_FMT;
      s_reg.txmask   <= afs_pkg::AFS_RST_MASK;
      s_reg.rxmask   <= afs_pkg::AFS_RST_MASK;
      s_reg.tx_oe_n  <= 1'b1;
      s_reg.tfs_oe_n <= 1'b1;
      s_reg.rfs_oe_n <= 1'b1;
      s_reg.wreq     <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  // Outputs straight from state flops
  assign avs_readdata_o           = s_reg.rdata;
  assign avs_waitrequest_o        = s_reg.wreq;
  assign tx_frame_sync_pin_o      = s_reg.tx.fs_gen;
  assign tx_frame_sync_pin_oe_n_o = s_reg.tfs_oe_n;
  assign rx_frame_sync_pin_o      = s_reg.rx.fs_gen;
  assign rx_frame_sync_pin_oe_n_o = s_reg.rfs_oe_n;
  assign serial_data_pin0_o       = s_reg.tx_pin;
  assign serial_data_pin0_oe_n_o  = s_reg.tx_oe_n;
  assign tx_dma_request_o         = s_reg.tx_dma;
  assign rx_dma_request_o         = s_reg.rx_dma;

  // Checks
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  a_shared_rx_clock: assert property (!indep |-> rx_ev == (rx_en & tck_rise)) // RL1
    else $error("rx not on tx clock");
  a_rxbc_ignored: assert property (!indep && rck_rise && !tck_rise |-> !rx_ev) // RL4
    else $error("rx clock used in shared mode");
  a_indep_rx_clock: assert property (indep && rx_en && !s_reg.rxbc |-> rx_ev == rck_rise) // RL5
    else $error("rx not on own clock");
  a_burst_idle: assert property (tx_ev && !s_reg.tx.in_frame && !tx_edge |-> !tx_go) // RL6
    else $error("shift outside frame");
  a_sync_delay: assert property (tx_ev && tx_edge |-> tx_go == (tdly == 2'h0)) // RL7
    else $error("bad sync delay");
  a_sync_width: assert property (tx_ev && s_reg.tx.fs_gen && s_reg.tx.fs_cnt == 5'h00
                                 |=> !s_reg.tx.fs_gen) // RL8
    else $error("sync too long");
  a_tx_sync_wait: assert property ($rose(s_reg.tx.fs_gen) && tx_cnt == afs_pkg::AFS_BURST
                                   |-> $past(s_reg.tx.full) && !$past(s_reg.tx.in_frame)) // RL9
    else $error("tx sync without data");
  a_rx_sync_wait: assert property ($rose(s_reg.rx.fs_gen) && rx_cnt == afs_pkg::AFS_BURST
                                   |-> !$past(s_reg.rx.full)) // RL10
    else $error("rx sync before read");
  a_frame_end: assert property (tx_go && tx_bit == tx_sz && tx_sl == tx_last
                                |=> !s_reg.tx.in_frame) // RL13
    else $error("frame did not end");
  a_inactive_quiet: assert property (rx_go && !rx_act |=> !s_reg.rx_dma) // RL14
    else $error("event in inactive slot");
  a_inactive_drive: assert property (tx_go && !tx_act
                                     |=> s_reg.tx_oe_n == (drv != afs_pkg::AFS_DRV_LOW
                                         && drv != afs_pkg::AFS_DRV_HIGH)) // RL15
    else $error("inactive drive wrong");
  a_tx_evt_cause: assert property (s_reg.tx_dma |-> $past(tx_req_c)) // RL16
    else $error("tx event without cause");
  a_tx_evt_copy: assert property (tx_copy && tx_nxt |=> s_reg.tx_dma ##1 !s_reg.tx_dma) // RL17
    else $error("copy raised no event");
  a_tx_evt_skip: assert property (tx_first && !tx_act && tx_nxt |=> s_reg.tx_dma) // RL18
    else $error("delayed event missing");
  a_rx_evt_data: assert property (s_reg.rx_dma |-> s_reg.rx.full) // RL19
    else $error("rx event before data");
  a_dir_slots: assert property (rx_go && rx_cnt == afs_pkg::AFS_DIR_SLOTS |-> rx_act) // RL20
    else $error("384 mode slot off");
  c_burst_tx: cover property (tx_copy && tx_cnt == afs_pkg::AFS_BURST);
  c_tdm_skip: cover property (tx_first && !tx_act && tx_nxt);
  c_dir_store: cover property (rx_store && rx_cnt == afs_pkg::AFS_DIR_SLOTS);
  c_shared_rx: cover property (!indep && rx_store);
endmodule : afs_seq_top

// >>> bench/afs_far_end.sv
// Purpose: Far-end codec model for the frame/slot sequencer
// Assumes: Bit clock runs free; clocks outside a frame are ignored
// Notes:   Lines change a quarter period after the bit clock rise
`timescale 1ns/1ps
module afs_far_end (
  // Clocks and syncs
  output logic      tx_bclk_o,
  output logic      rx_bclk_o,
  output logic      tx_fs_o,
  output logic      rx_fs_o,
  // Serial data
  output logic      rx_dat_o,
  input  wire logic tx_dat_i,
  input  wire logic tx_oe_n_i
);
  // Quiet lines at start; receive clock runs in antiphase to transmit
  initial begin
    tx_bclk_o = 1'b0;
    rx_bclk_o = 1'b1;
    tx_fs_o = 1'b0;
    rx_fs_o = 1'b0;
    rx_dat_o = 1'b0;
  end
  // 200 ns bit clock
  always #100 tx_bclk_o = ~tx_bclk_o;
  // Shared mode must ignore it; independent mode with rxbc set samples on its fall
  always #100 rx_bclk_o = ~rx_bclk_o;
  // Sync, d filler bits, n data bits, then idle bits
  task automatic frame(input int d, input int n, input logic [63:0] w,
                       output logic [63:0] cap, output logic [63:0] oe);
    cap = 64'h0;
    oe = 64'h0;
    @(posedge tx_bclk_o);
    #50;
    for (int j = 0; j < n + d + 4; j++) begin
      tx_fs_o = (j == 0);
      // Outside the word the line toggles, never holds a stale bit
      if (j >= d && j < n + d) rx_dat_o = w[63 - ((j - d) % 64)];
      else rx_dat_o = ~rx_dat_o;
      #50;
      if (j > d && j <= n + d) begin
        cap = {cap[62:0], tx_dat_i};
        oe = {oe[62:0], tx_oe_n_i};
      end
      #150;
    end
  endtask : frame
endmodule : afs_far_end

// >>> bench/afs_seq_top_test.sv
// Purpose: Self-checking bench for the audio frame/slot sequencer
// Assumes: Shared clocking with external syncs except the last two tests
// Notes:   Expected values are worked out here, never read back
`timescale 1ns/1ps
module afs_seq_top_test;
  logic        clk_sys_i = 1'b0;
  logic        rst_i = 1'b1;
  logic [7:0]  adr = 8'h00;
  logic        rd_en = 1'b0;
  logic        wr_en = 1'b0;
  logic [31:0] wdat = 32'h0000_0000;
  logic [31:0] rdat, rdata_o;
  logic        wait_o, tfs_o, tfs_oe_n, dat_o, dat_oe_n, tdma, rdma, rfs_o, rfs_oe_n;
  logic        tbclk, rbclk, tfs, tfs_w, rfs, rdat_pin;
  logic [63:0] cap, oe, w;
  logic [7:0]  m;
  int          err_total = 0, compares = 0, cyc = 0, tdn = 0, rdn = 0;
  int          t0, r0, n, seed = 32'h0000_226d;
  // Two-way sync wire: design wins while its enable is low
  assign tfs_w = (tfs_oe_n === 1'b0) ? tfs_o : tfs;
  always #12.5 clk_sys_i = ~clk_sys_i;
  afs_seq_top u_dut (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .avs_address_i(adr), .avs_read_i(rd_en),
    .avs_write_i(wr_en), .avs_writedata_i(wdat), .avs_byteenable_i(4'hF),
    .avs_readdata_o(rdata_o), .avs_waitrequest_o(wait_o),
    .tx_bit_clock_pin_i(tbclk), .rx_bit_clock_pin_i(rbclk),
    .tx_frame_sync_pin_i(tfs_w), .tx_frame_sync_pin_o(tfs_o),
    .tx_frame_sync_pin_oe_n_o(tfs_oe_n), .rx_frame_sync_pin_i(rfs),
    .rx_frame_sync_pin_o(rfs_o), .rx_frame_sync_pin_oe_n_o(rfs_oe_n),
    .serial_data_pin0_o(dat_o),
    .serial_data_pin0_oe_n_o(dat_oe_n), .serial_data_pin1_i(rdat_pin),
    .tx_dma_request_o(tdma), .rx_dma_request_o(rdma));
  afs_far_end u_far (.tx_bclk_o(tbclk), .rx_bclk_o(rbclk), .tx_fs_o(tfs), .rx_fs_o(rfs),
    .rx_dat_o(rdat_pin), .tx_dat_i(dat_o), .tx_oe_n_i(dat_oe_n));
  // Count DMA pulses; cut a hang short
  always @(posedge clk_sys_i) begin
    tdn <= tdn + int'(tdma === 1'b1);
    rdn <= rdn + int'(rdma === 1'b1);
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total = err_total + 1;
      summarize();
    end
  end
  // Control word: both delays d, inactive drive, both sequencers on
  function automatic logic [31:0] ctl(input int d, input int drv);
    return 32'h0000_1800 | (d << afs_pkg::AFS_C_TXDLY) | (d << afs_pkg::AFS_C_RXDLY)
           | (drv << afs_pkg::AFS_C_DRV);
  endfunction : ctl
  // One Avalon transfer, held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys_i);
    adr <= a;
    wr_en <= wr;
    rd_en <= ~wr;
    wdat <= d;
    do @(posedge clk_sys_i); while (wait_o !== 1'b0);
    rdat = rdata_o;
    wr_en <= 1'b0;
    rd_en <= 1'b0;
  endtask : bus
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    compares++;
    if (got !== exp) begin
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
      err_total++;
    end
  endtask : chk
  task automatic summarize();
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : summarize
  initial begin
    repeat (10) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    // Reset values; status is read-only; unmapped reads as zero
    bus(1, afs_pkg::AFS_OFS_STAT, 32'hFFFF_FFFF);
    bus(1, 8'h40, 32'hFFFF_FFFF);
    bus(0, afs_pkg::AFS_OFS_CTRL, 0);
    chk(rdat, afs_pkg::AFS_RST_CTRL);
    bus(0, afs_pkg::AFS_OFS_STAT, 0);
    chk(rdat, 0);
    bus(0, 8'h40, 0);
    chk(rdat, 0);
    $display("register test done");
    // Burst mode, delays 0, 1 and 2; receive clock control must be ignored
    bus(1, afs_pkg::AFS_OFS_RXBC, 32'h0000_0001);
    bus(1, afs_pkg::AFS_OFS_TXFMT, 32'h0007_0000);
    bus(1, afs_pkg::AFS_OFS_RXFMT, 32'h0007_0000);
    bus(1, afs_pkg::AFS_OFS_TXMASK, 32'h0000_0001);
    bus(1, afs_pkg::AFS_OFS_RXMASK, 32'h0000_0001);
    for (int d = 0; d < 3; d++) begin
      bus(1, afs_pkg::AFS_OFS_CTRL, ctl(d, 0));
      w = {$random(seed), $random(seed)};
      bus(1, afs_pkg::AFS_OFS_TXDATA, w[31:0]);
      t0 = tdn;
      r0 = rdn;
      u_far.frame(d, 8, w, cap, oe);
      chk(cap[7:0], w[7:0]);
      chk(tdn - t0, 1);
      chk(rdn - r0, 1);
      bus(0, afs_pkg::AFS_OFS_RXDATA, 0);
      chk(rdat[7:0], w[63:56]);
      $display("burst delay %0d test done", d);
    end
    // Four-slot frames, random masks plus one hand-picked corner
    bus(1, afs_pkg::AFS_OFS_TXFMT, 32'h0007_0004);
    bus(1, afs_pkg::AFS_OFS_RXFMT, 32'h0007_0004);
    for (int drv = 0; drv < 3; drv++) begin
      m = (drv == 0) ? 8'h5E : 8'($random(seed));
      bus(1, afs_pkg::AFS_OFS_CTRL, ctl(0, drv));
      bus(1, afs_pkg::AFS_OFS_TXMASK, {28'h000_0000, m[3:0]});
      bus(1, afs_pkg::AFS_OFS_RXMASK, {28'h000_0000, m[7:4]});
      t0 = tdn;
      r0 = rdn;
      u_far.frame(0, 32, w, cap, oe);
      for (int s = 0; s < 4; s++) begin
        if (!m[s] && drv == 0) chk(oe[31-8*s -: 8], 8'hFF);
        else if (!m[s]) chk({oe[31-8*s -: 8], cap[31-8*s -: 8]}, {8'h00, {8{drv[1]}}});
      end
      chk(tdn - t0, $countones(m[3:0]));
      chk(rdn - r0, $countones(m[7:4]));
      $display("slot drive %0d test done", drv);
    end
    // 384-slot receive block of two-bit slots
    bus(1, afs_pkg::AFS_OFS_CTRL, 32'h0000_1000);
    bus(1, afs_pkg::AFS_OFS_RXFMT, 32'h0001_0180);
    bus(1, afs_pkg::AFS_OFS_RXMASK, 32'hFFFF_FFFF);
    r0 = rdn;
    u_far.frame(0, 768, w, cap, oe);
    chk(rdn - r0, 384);
    $display("block receive test done");
    // Internal burst sync waits for new transmit data
    bus(1, afs_pkg::AFS_OFS_TXFMT, 32'h0007_0000);
    bus(1, afs_pkg::AFS_OFS_CTRL, 32'h0000_0802);
    n = 0;
    repeat (400) @(posedge clk_sys_i) n += int'(tfs_o === 1'b1);
    chk(n, 0);
    bus(1, afs_pkg::AFS_OFS_TXDATA, 32'h0000_00A5);
    n = 0;
    while (tfs_o !== 1'b1 && n < 800) @(posedge clk_sys_i) n++;
    chk({tfs_o, tfs_oe_n}, 2'b10);
    n = 0;
    while (tfs_o === 1'b1 && n < 100) @(posedge clk_sys_i) n++;
    chk(n >= 7 && n <= 9, 1);
    $display("internal sync test done");
    // Own receive clock, transmit off; buffer still full from block test
    bus(1, afs_pkg::AFS_OFS_RXFMT, 32'h0007_0000);
    bus(1, afs_pkg::AFS_OFS_CTRL, 32'h0000_1005);
    r0 = rdn;
    n = 0;
    repeat (400) @(posedge clk_sys_i) n += int'(rfs_o === 1'b1);
    chk(n, 0);
    bus(0, afs_pkg::AFS_OFS_RXDATA, 0);
    n = 0;
    repeat (300) @(posedge clk_sys_i) n += int'(rfs_o === 1'b1);
    chk(n, 8);
    chk(rdn - r0, 1);
    chk(rfs_oe_n, 0);
    $display("independent receive test done");
    summarize();
  end
endmodule : afs_seq_top_test
